// *** include/scm_consts.svh ***
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

// Array geometry: 2048 words of 32 bits plus one overflow word
`define SCM_WORD_W       32
`define SCM_ADDR_W       12
`define SCM_BIT_W        5
`define SCM_MEM_DEPTH    2049
`define SCM_BUF_DEPTH    2

// Counter values
`define SCM_ADDR_ZERO    12'h000
`define SCM_ADDR_ONE     12'h001
`define SCM_LAST_WORD    12'h7ff
`define SCM_OVF_ADDR     12'h800
`define SCM_BIT_ZERO     5'h00
`define SCM_BIT_ONE      5'h01
`define SCM_LAST_BIT     5'h1f
`define SCM_MSB          31

// Polarity word and defaults
`define SCM_POL_LOW_WORD 32'h00000000
`define SCM_POL_DEFAULT  1'b1
`define SCM_WORD_ZERO    32'h00000000

// Pin idle levels: prog, cs_n, rst_oe, data
`define SCM_PINS_IDLE    4'h4

`endif

// *** include/scm_pkg.sv ***
`include "scm_consts.svh"

package scm_pkg;

    typedef logic [`SCM_WORD_W-1:0] scm_word_type;
    typedef logic [`SCM_ADDR_W-1:0] scm_addr_type;
    typedef logic [`SCM_BIT_W-1:0]  scm_bit_type;

    // Read or program position: word address and bit within it
    typedef struct packed {
        scm_addr_type addr;
        scm_bit_type  bit_idx;
    } scm_pos_type;

    // Pins as sampled from outside the clock domain
    typedef struct packed {
        logic prog;
        logic cs_n;
        logic rst_oe;
        logic data;
    } scm_pins_type;

    typedef enum logic [2:0] {
        SCM_ST_RUN        = 3'b001,
        SCM_ST_END_HOLD   = 3'b010,
        SCM_ST_END_FOLLOW = 3'b100
    } scm_ceo_state_type;

endpackage : scm_pkg

// *** rtl/scm_word_buf.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "scm_consts.svh"

module scm_word_buf #(
    parameter int WIDTH = `SCM_WORD_W,
    parameter int DEPTH = `SCM_BUF_DEPTH
) (
    input  wire logic             clock_i,     // Clock
    input  wire logic             arst_n_i,    // Async reset, active low
    input  wire logic             flush_i,     // Drop all entries
    input  wire logic             in_valid_i,  // Write request
    output logic                  in_ready_o,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data
    output logic                  out_valid_o, // Word available
    input  wire logic             out_ready_i, // Reader takes word
    output logic [WIDTH-1:0]      out_data_o   // Oldest word
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_q != (PW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = store_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o & ~flush_i;
    assign pop         = out_valid_o & out_ready_i & ~flush_i;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : next_ptr

    always_ff @(posedge clock_i) begin
        if (push) begin
            store_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (flush_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= next_ptr(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= next_ptr(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + (PW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (PW+1)'(1);
            end
        end
    end

endmodule : scm_word_buf

`default_nettype wire

// *** rtl/scm_reader.sv ***
//
// Overview of operation
// - Stores 2048 words of 32 bits, read sequentially
// - One new data bit per enabled clock edge
// - Data pin drives when reading, input when programming
// - Each driven edge advances bit counter, every 32nd the word counter
// - Output drives only with chip select and gate active
// - When reading, reset level clears word and bit counters
// - Reset level polarity chosen at programming
// - Overflow word zeros gives active low reset
// - When reading, chip select high freezes counters, standby
// - Standby keeps data released regardless of gate
// - Chain output low on cycle after last bit
// - Chain low while selected, then mirrors select
// - After reset level chain stays high until reread
// - Chain output reports polarity in programming mode
// - Data released together with chain output falling
// - Downstream device continues stream on chain low
// - Shared reset level clears every cascaded counter
//
`timescale 1ns/1ps
`default_nettype none

`include "scm_consts.svh"

module scm_reader (
    input  wire logic clock_i,              // Serial clock
    input  wire logic arst_n_i,             // Async reset, active low
    input  wire logic chip_sel_n_i,         // Chip select pin, active low
    input  wire logic reset_oe_i,           // Reset / output gate pin
    input  wire logic prog_mode_i,          // Programming mode pin
    input  wire logic data_i,               // Data pin, input side
    output logic      data_o,               // Data pin, output side
    output logic      data_oe_o,            // Data pin drive enable
    output logic      chain_enable_out_n_o, // Chain enable to next part
    output logic      standby_o             // Low power standby state
);

    // Pin synchronisers and agreement filter
    scm_pkg::scm_pins_type pins_raw;
    scm_pkg::scm_pins_type pins_s1_q;
    scm_pkg::scm_pins_type pins_s2_q;
    scm_pkg::scm_pins_type pins_s3_q;
    scm_pkg::scm_pins_type pins_q;

    // Array and positions
    scm_pkg::scm_word_type mem [`SCM_MEM_DEPTH];
    scm_pkg::scm_pos_type  pos_q;
    scm_pkg::scm_addr_type fetch_q;
    scm_pkg::scm_word_type shift_q;
    scm_pkg::scm_word_type prog_word_q;
    scm_pkg::scm_word_type prog_word_full;

    logic shift_valid_q;
    logic shift_valid_d;
    logic done_q;
    logic done_d;
    logic pol_high_q;
    logic prog_q;
    logic data_oe_q;
    logic ceo_q;
    logic ceo_d;
    logic standby_q;

    scm_pkg::scm_ceo_state_type ceo_st_q;
    scm_pkg::scm_ceo_state_type ceo_st_d;

    // Decoded controls
    logic prog;
    logic cs_n;
    logic rst_lvl;
    logic clear;
    logic prog_enter;
    logic prog_step;
    logic advance;
    logic last_bit;
    logic last_word;
    logic finish;

    // Buffer handshake
    logic                  buf_in_valid;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic                  buf_out_ready;
    scm_pkg::scm_word_type buf_out_data;
    logic                  load;

    assign pins_raw.prog   = prog_mode_i;
    assign pins_raw.cs_n   = chip_sel_n_i;
    assign pins_raw.rst_oe = reset_oe_i;
    assign pins_raw.data   = data_i;

    // Three stages; a change is taken once stages two and three agree
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_s1_q <= scm_pkg::scm_pins_type'(`SCM_PINS_IDLE);
            pins_s2_q <= scm_pkg::scm_pins_type'(`SCM_PINS_IDLE);
            pins_s3_q <= scm_pkg::scm_pins_type'(`SCM_PINS_IDLE);
            pins_q    <= scm_pkg::scm_pins_type'(`SCM_PINS_IDLE);
        end else begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
            pins_q    <= (pins_s2_q & pins_s3_q)
                       | (pins_q & (pins_s2_q ^ pins_s3_q));
            // Programming data changes on every edge, so the filter would
            // drop lone bits; stage three keeps it in step with the gate pin
            pins_q.data <= pins_s3_q.data;
        end
    end

    assign prog    = pins_q.prog;
    assign cs_n    = pins_q.cs_n;
    // Gate pin meaning depends on programmed polarity
    assign rst_lvl = pol_high_q ? pins_q.rst_oe : ~pins_q.rst_oe;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_q <= 1'b0;
        end else begin
            prog_q <= prog;
        end
    end

    assign prog_enter = prog & ~prog_q;
    // Polarity is ignored while programming; entry clears instead
    assign clear      = prog ? prog_enter : rst_lvl;
    // Programming shifts in while select and gate pin are both high
    assign prog_step  = prog & ~clear & cs_n & pins_q.rst_oe;

    assign last_bit  = (pos_q.bit_idx == `SCM_LAST_BIT);
    assign last_word = (pos_q.addr == `SCM_LAST_WORD);
    // Only a driven bit moves on, so a pause neither drops nor repeats one;
    // the driver already folds in select, gate, programming and done
    assign advance   = data_oe_q & ~clear;
    assign finish    = advance & last_bit & last_word;

    // Word fetch ahead of the shifter, stopped by buffer back-pressure
    assign buf_in_valid = ~prog & ~clear & (fetch_q <= `SCM_LAST_WORD);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fetch_q <= `SCM_ADDR_ZERO;
        end else if (clear) begin
            fetch_q <= `SCM_ADDR_ZERO;
        end else if (buf_in_valid && buf_in_ready) begin
            fetch_q <= fetch_q + `SCM_ADDR_ONE;
        end
    end

    // Shifter asks for a word when empty or when its last bit goes out
    assign buf_out_ready = ~clear & ~prog
                         & (~shift_valid_q
                            | (advance & last_bit & ~last_word));
    assign load          = buf_out_ready & buf_out_valid;

    scm_word_buf #(
        .WIDTH (`SCM_WORD_W),
        .DEPTH (`SCM_BUF_DEPTH)
    ) u_buf (
        .clock_i     (clock_i),
        .arst_n_i    (arst_n_i),
        .flush_i     (clear),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (mem[fetch_q]),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    always_comb begin
        shift_valid_d = shift_valid_q;
        done_d        = done_q;
        if (clear) begin
            shift_valid_d = 1'b0;
            done_d        = 1'b0;
        end else if (load) begin
            shift_valid_d = 1'b1;
        end else if (advance && last_bit) begin
            shift_valid_d = 1'b0;
            done_d        = finish;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_valid_q <= 1'b0;
            done_q        <= 1'b0;
        end else begin
            shift_valid_q <= shift_valid_d;
            done_q        <= done_d;
        end
    end

    // Serial word out, most significant bit first
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_q <= `SCM_WORD_ZERO;
        end else if (clear) begin
            shift_q <= `SCM_WORD_ZERO;
        end else if (load) begin
            shift_q <= buf_out_data;
        end else if (advance) begin
            shift_q <= {shift_q[`SCM_MSB-1:0], 1'b0};
        end
    end

    // Shared bit and word counters for reading and programming
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_q.addr    <= `SCM_ADDR_ZERO;
            pos_q.bit_idx <= `SCM_BIT_ZERO;
        end else if (clear) begin
            pos_q.addr    <= `SCM_ADDR_ZERO;
            pos_q.bit_idx <= `SCM_BIT_ZERO;
        end else if (prog_step) begin
            pos_q.bit_idx <= pos_q.bit_idx + `SCM_BIT_ONE;
            if (last_bit && pos_q.addr != `SCM_OVF_ADDR) begin
                pos_q.addr <= pos_q.addr + `SCM_ADDR_ONE;
            end
        end else if (advance) begin
            pos_q.bit_idx <= pos_q.bit_idx + `SCM_BIT_ONE;
            // Last word keeps its address; done blocks any wrap
            if (last_bit && !last_word) begin
                pos_q.addr <= pos_q.addr + `SCM_ADDR_ONE;
            end
        end
    end

    // Programming: collect a word, write it on its last bit
    assign prog_word_full = {prog_word_q[`SCM_MSB-1:0], pins_q.data};

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_word_q <= `SCM_WORD_ZERO;
        end else if (prog_step) begin
            prog_word_q <= prog_word_full;
        end
    end

    // Array has no reset; contents exist only once programmed
    always_ff @(posedge clock_i) begin
        if (prog_step && last_bit) begin
            mem[pos_q.addr] <= prog_word_full;
        end
    end

    // Polarity held in a flop, updated when the overflow word is written;
    // any word other than all zeros keeps the active high default
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pol_high_q <= `SCM_POL_DEFAULT;
        end else if (prog_step && last_bit
                     && pos_q.addr == `SCM_OVF_ADDR) begin
            pol_high_q <= (prog_word_full != `SCM_POL_LOW_WORD);
        end
    end

    // Driver on only when selected, gated on, and not past the end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= ~prog & ~cs_n & ~rst_lvl
                       & shift_valid_d & ~done_d;
        end
    end

    // Chain enable state
    always_comb begin
        ceo_st_d = ceo_st_q;
        case (ceo_st_q)
            scm_pkg::SCM_ST_RUN: begin
                if (finish) begin
                    ceo_st_d = scm_pkg::SCM_ST_END_HOLD;
                end
            end
            scm_pkg::SCM_ST_END_HOLD: begin
                if (rst_lvl) begin
                    ceo_st_d = scm_pkg::SCM_ST_RUN;
                end else if (cs_n) begin
                    ceo_st_d = scm_pkg::SCM_ST_END_FOLLOW;
                end
            end
            scm_pkg::SCM_ST_END_FOLLOW: begin
                if (rst_lvl) begin
                    ceo_st_d = scm_pkg::SCM_ST_RUN;
                end
            end
            default: begin
                ceo_st_d = scm_pkg::SCM_ST_RUN;
            end
        endcase
    end

    always_comb begin
        case (ceo_st_d)
            scm_pkg::SCM_ST_END_HOLD:   ceo_d = 1'b0;
            scm_pkg::SCM_ST_END_FOLLOW: ceo_d = cs_n;
            default:                    ceo_d = 1'b1;
        endcase
        // In programming mode the pin shows the stored polarity
        if (prog) begin
            ceo_d = pol_high_q;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ceo_st_q <= scm_pkg::SCM_ST_RUN;
        end else begin
            ceo_st_q <= ceo_st_d;
        end
    end

    // Next part in a chain sees this as its select
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ceo_q <= 1'b1;
        end else begin
            ceo_q <= ceo_d;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            standby_q <= 1'b1;
        end else begin
            standby_q <= cs_n & ~prog;
        end
    end

    assign data_o               = shift_q[`SCM_MSB];
    assign data_oe_o            = data_oe_q;
    assign chain_enable_out_n_o = ceo_q;
    assign standby_o            = standby_q;

endmodule : scm_reader

`default_nettype wire

// *** test/scm_reader_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_reader_assertions (
    input wire logic clock_i,              // Serial clock
    input wire logic arst_n_i,             // Async reset, active low
    input wire logic chip_sel_n_i,         // Chip select pin
    input wire logic reset_oe_i,           // Reset / output gate pin
    input wire logic prog_mode_i,          // Programming mode pin
    input wire logic data_i,               // Data pin, input side
    input wire logic data_o,               // Data pin, output side
    input wire logic data_oe_o,            // Data pin drive enable
    input wire logic chain_enable_out_n_o, // Chain enable out
    input wire logic standby_o             // Standby state
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    // Edges since select, gate or programming pin was last high
    logic [3:0] quiet_q;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet_q <= 4'h0;
        end else if (chip_sel_n_i || reset_oe_i || prog_mode_i) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // Set once a bit was driven; a reset level or programming empties the
    // shifter, which may then load its first word while in standby
    logic shown_q;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shown_q <= 1'b0;
        end else if (reset_oe_i || prog_mode_i) begin
            shown_q <= 1'b0;
        end else if (data_oe_o) begin
            shown_q <= 1'b1;
        end
    end

    // Six samples cover the pin synchroniser plus the output flop
    sequence deselected_s;
        (chip_sel_n_i && !prog_mode_i) [*6];
    endsequence

    sequence gated_s;
        (reset_oe_i && !prog_mode_i) [*6];
    endsequence

    sel_gates_drive_a: assert property (deselected_s |-> !data_oe_o)
        else $error("data driven while deselected");
    reset_gates_drive_a: assert property (gated_s |-> !data_oe_o)
        else $error("data driven while gate inactive");
    standby_on_a: assert property (deselected_s |-> standby_o)
        else $error("no standby while deselected");
    standby_off_a: assert property (
        (!chip_sel_n_i && !prog_mode_i) [*6] |-> !standby_o)
        else $error("standby while selected");
    freeze_data_a: assert property (
        standby_o && $past(standby_o) && shown_q |-> $stable(data_o))
        else $error("data moved in standby");
    chain_low_quiet_a: assert property (
        !chain_enable_out_n_o |-> !data_oe_o)
        else $error("data driven with chain low");
    chain_deselect_a: assert property (
        deselected_s |-> chain_enable_out_n_o)
        else $error("chain not following select");
    chain_gate_high_a: assert property (
        gated_s |-> chain_enable_out_n_o)
        else $error("chain low during reset level");
    rise_has_cause_a: assert property (
        $rose(chain_enable_out_n_o) || $rose(data_oe_o) |-> quiet_q < 4'hc)
        else $error("output rose without pin cause");
    prog_quiet_a: assert property (
        prog_mode_i [*6] |-> !data_oe_o && chain_enable_out_n_o)
        else $error("wrong outputs in programming");
endmodule : scm_reader_assertions

bind scm_reader scm_reader_assertions i_scm_reader_assertions (
    .clock_i, .arst_n_i, .chip_sel_n_i, .reset_oe_i, .prog_mode_i,
    .data_i, .data_o, .data_oe_o, .chain_enable_out_n_o, .standby_o
);

`default_nettype wire

// *** test/scm_fpga_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_fpga_model (
    input  wire logic  clock_i,    // Serial clock
    input  wire logic  clr_i,      // Clear taken bit count
    input  wire logic  dev_data_i, // Device data out
    input  wire logic  dev_oe_i,   // Device drive enable
    input  wire logic  prog_bit_i, // Programmer bit
    input  wire logic  prog_en_i,  // Programmer drives pin
    output logic       pin_o,      // Resolved data pin
    output logic [63:0] cap_o,     // Last bits taken, newest at 0
    output logic [16:0] cnt_o      // Bits taken since clear
);
    // Pull-up on the pin: a released line reads high
    assign pin_o = dev_oe_i ? dev_data_i : (prog_en_i ? prog_bit_i : 1'b1);

    always_ff @(posedge clock_i) begin
        if (clr_i) begin
            cnt_o <= 17'h00000;
        end else if (dev_oe_i) begin
            cap_o <= {cap_o[62:0], pin_o};
            cnt_o <= cnt_o + 17'h00001;
        end
    end
endmodule : scm_fpga_model

`default_nettype wire

// *** test/scm_reader_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_reader_test;
    localparam logic [63:0] IMAGE = 64'ha5c30f96_3c5ae71b;

    logic        clock_i, arst_n_i, chip_sel_n_i, reset_oe_i, prog_mode_i;
    logic        prog_en, prog_bit, cap_clr, pin, got_all, mid_way;
    logic        data_o, data_oe_o, chain_n, standby_o;
    logic [63:0] cap;
    logic [16:0] cnt;
    int          err_total;
    int          samples_checked;

    assign got_all = (cnt >= 17'h00040);
    assign mid_way = (cnt >= 17'h00028);

    scm_reader i_scm_reader (
        .clock_i              (clock_i),
        .arst_n_i             (arst_n_i),
        .chip_sel_n_i         (chip_sel_n_i),
        .reset_oe_i           (reset_oe_i),
        .prog_mode_i          (prog_mode_i),
        .data_i               (pin),
        .data_o               (data_o),
        .data_oe_o            (data_oe_o),
        .chain_enable_out_n_o (chain_n),
        .standby_o            (standby_o)
    );

    scm_fpga_model i_scm_fpga_model (
        .clock_i    (clock_i),
        .clr_i      (cap_clr),
        .dev_data_i (data_o),
        .dev_oe_i   (data_oe_o),
        .prog_bit_i (prog_bit),
        .prog_en_i  (prog_en),
        .pin_o      (pin),
        .cap_o      (cap),
        .cnt_o      (cnt)
    );

    always #50 clock_i = ~clock_i;

    task automatic test_done();
        $display("Checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s: expected %b, seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [63:0] exp,
                            input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    function automatic logic probe(input logic [1:0] sel);
        case (sel)
            2'h0:    probe = got_all;
            2'h1:    probe = mid_way;
            2'h2:    probe = data_oe_o;
            default: probe = chain_n;
        endcase
    endfunction : probe

    task automatic wait_for(input string what, input logic [1:0] sel,
                            input logic lvl, input int bound);
        int n;
        n = 0;
        while (probe(sel) !== lvl) begin
            @(negedge clock_i);
            n++;
            if (n > bound) begin
                err_total++;
                $display("Error %s: expected %b, seen %b", what, lvl,
                         probe(sel));
                test_done();
            end
        end
    endtask : wait_for

    task automatic t_reset_vals();
        @(negedge clock_i);
        chk_bit("drive enable", 1'b0, data_oe_o);
        chk_bit("chain out", 1'b1, chain_n);
        chk_bit("standby", 1'b1, standby_o);
        $display("Test reset values done");
    endtask : t_reset_vals

    // Gate pin held low on entry so no idle bits are shifted in
    task automatic t_program();
        @(posedge clock_i);
        prog_mode_i <= 1'b1;
        cyc(8);
        for (int i = 63; i >= 0; i--) begin
            reset_oe_i <= 1'b1;
            prog_en    <= 1'b1;
            prog_bit   <= IMAGE[i];
            @(posedge clock_i);
        end
        reset_oe_i <= 1'b0;
        prog_en    <= 1'b0;
        cyc(8);
        @(negedge clock_i);
        chk_bit("drive enable", 1'b0, data_oe_o);
        chk_bit("released pin", 1'b1, pin);
        chk_bit("chain out", 1'b1, chain_n);
        @(posedge clock_i);
        prog_mode_i <= 1'b0;
        cyc(8);
        $display("Test program done");
    endtask : t_program

    // Reset level with select low starts a fresh read from word zero
    task automatic restart();
        @(posedge clock_i);
        reset_oe_i   <= 1'b1;
        chip_sel_n_i <= 1'b0;
        cap_clr      <= 1'b1;
        cyc(8);
        reset_oe_i <= 1'b0;
        cap_clr    <= 1'b0;
    endtask : restart

    task automatic t_read();
        restart();
        wait_for("bit count", 2'h0, 1'b1, 100);
        chk_word("read image", IMAGE, cap);
        chk_bit("chain out", 1'b1, chain_n);
        $display("Test read done");
    endtask : t_read

    // Pause inside the programmed words, so the held bit is a known one
    task automatic t_freeze();
        logic held;
        restart();
        wait_for("bit count", 2'h1, 1'b1, 100);
        @(posedge clock_i);
        chip_sel_n_i <= 1'b1;
        cyc(8);
        @(negedge clock_i);
        chk_bit("drive enable", 1'b0, data_oe_o);
        chk_bit("standby", 1'b1, standby_o);
        held = data_o;
        cyc(20);
        @(negedge clock_i);
        chk_bit("held bit", held, data_o);
        @(posedge clock_i);
        chip_sel_n_i <= 1'b0;
        wait_for("drive enable", 2'h2, 1'b1, 10);
        chk_bit("standby", 1'b0, standby_o);
        wait_for("bit count", 2'h0, 1'b1, 100);
        chk_word("paused image", IMAGE, cap);
        $display("Test freeze done");
    endtask : t_freeze

    task automatic t_end();
        wait_for("chain out", 2'h3, 1'b0, 70000);
        chk_bit("drive enable", 1'b0, data_oe_o);
        chk_bit("released pin", 1'b1, pin);
        cyc(40);
        @(negedge clock_i);
        chk_bit("drive enable", 1'b0, data_oe_o);
        chk_bit("chain out", 1'b0, chain_n);
        @(posedge clock_i);
        chip_sel_n_i <= 1'b1;
        cyc(8);
        @(negedge clock_i);
        chk_bit("chain out", 1'b1, chain_n);
        @(posedge clock_i);
        chip_sel_n_i <= 1'b0;
        cyc(8);
        @(negedge clock_i);
        chk_bit("chain out", 1'b0, chain_n);
        chk_bit("drive enable", 1'b0, data_oe_o);
        $display("Test end of array done");
    endtask : t_end

    initial begin
        clock_i         = 1'b0;
        arst_n_i        = 1'b0;
        chip_sel_n_i    = 1'b1;
        reset_oe_i      = 1'b0;
        prog_mode_i     = 1'b0;
        prog_en         = 1'b0;
        prog_bit        = 1'b0;
        cap_clr         = 1'b1;
        err_total       = 0;
        samples_checked = 0;
        cyc(20);
        arst_n_i <= 1'b1;
        cyc(6);
        t_reset_vals();
        t_program();
        t_read();
        t_freeze();
        t_end();
        t_read();
        test_done();
    end
endmodule : scm_reader_test

`default_nettype wire
